// ===== hw/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter mode, sync and settle control
// Assumes: one master clock at 50 MHz drives everything
// Notes:   ratios are master clock cycles per conversion period
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_HIGH_SPEED = 2'b00,
    MODE_HIGH_RES   = 2'b01,
    MODE_LOW_POWER  = 2'b10,
    MODE_LOW_SPEED  = 2'b11
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_HALTED   = 2'b00,
    ST_SETTLING = 2'b01,
    ST_RUNNING  = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic     syncN;
    logic     clockDividerSelect;
    op_mode_e mode;
  } ctrl_pins_s;

  localparam int          RATIO_W        = 12;
  localparam int          SETTLE_W       = 8;
  localparam int          CHANNELS       = 8;
  localparam logic [11:0] RATIO_256      = 12'h100;
  localparam logic [11:0] RATIO_512      = 12'h200;
  localparam logic [11:0] RATIO_2560     = 12'hA00;
  localparam logic [7:0]  SETTLE_SPI     = 8'h81;
  localparam logic [7:0]  SETTLE_FS      = 8'h80;
  localparam logic [7:0]  SETTLE_FS_MIN  = 8'h7F;
  localparam logic [2:0]  FORMAT_FS_LO   = 3'h3;
  localparam logic [2:0]  FORMAT_FS_HI   = 3'h5;
  localparam real         MIN_CLK_KHZ    = 100.0;
  localparam real         MAX_CLK_HS_MHZ = 32.768;
  localparam real         MAX_CLK_MHZ    = 27.0;
  localparam real         SYNC_MIN_CLK   = 1.0;
  localparam int          CTRL_RESET     = 4'hF;

endpackage

// ===== hw/sync_two_stage.sv
// Purpose: two flip-flop level synchroniser
// Assumes: destination clock is the master clock
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module sync_two_stage #(
  parameter int          WIDTH     = 1,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // level in and out
  input  wire logic [WIDTH-1:0] levelIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1Reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1Reg <= RESET_VAL[WIDTH-1:0];
      levelOut  <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1Reg <= levelIn;
      levelOut  <= stage1Reg;
    end
  end

endmodule

// ===== hw/adc_mode_clock_sync_control.sv
// Purpose: mode decode, data-rate timing, sync and settled-data flagging
// Assumes: pins synchronous to clock; host keeps its own timing duties
// Notes:   one conversion-period pulse serves all eight channels
//
// Behaviour
// RULE_01 - all channels run from one master clock
// RULE_02 - decode two mode bits into four modes
// RULE_03 - clock per sample ratio from mode, divider
// RULE_04 - host keeps master clock under mode maximum
// RULE_05 - divider select picks clock at top rate
// RULE_06 - data rate follows master clock down to 100kHz
// RULE_07 - watch mode pins continuously while running
// RULE_08 - spi ready held high after mode change
// RULE_09 - frame-sync data forced low after mode change
// RULE_10 - host may poll for first one bit
// RULE_11 - sync low halts and clears filter counters
// RULE_12 - sync high restarts from cleared state
// RULE_13 - channels always stay mutually aligned
// RULE_14 - shared sync aligns devices within one clock
// RULE_15 - spi ready rises when sync falls
// RULE_16 - spi ready falls once filter settled
// RULE_17 - frame-sync data forced low on sync fall
// RULE_18 - frame-sync data resumes after settling
// RULE_19 - host keeps strobe and clocks running
// RULE_20 - host resyncs after clock interruption
// RULE_21 - host resyncs after power-on data
// RULE_22 - sync pulse one clock; spi ready within 129
// RULE_23 - format code picks spi or frame-sync
// RULE_24 - spi ready falls when data available
// RULE_25 - control pins pass two-stage synchroniser; format is used unsynchronised
// RULE_26 - settle counter restarted, gates data valid
`timescale 1ns/1ns
module adc_mode_clock_sync_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // control pins
  input  wire logic [1:0]          mode,
  input  wire logic                clockDividerSelect,
  input  wire logic                syncN,
  input  wire logic [2:0]          format,
  // raw channel data from the filters
  input  wire logic [CHANNELS-1:0] rawData,
  // status and data outputs
  output logic                     sample_ready_n,
  output logic [CHANNELS-1:0]      dataOut,
  output logic                     convStrobe,
  output logic                     filterClear,
  output logic                     dataValid,
  output logic [RATIO_W-1:0]       ratioOut,
  output logic [1:0]               modeOut
);

  ctrl_pins_s          pinsRaw;
  ctrl_pins_s          pinsSync;
  ctrl_pins_s          pinsPrev_reg;
  logic [RATIO_W-1:0]  ratio_next;
  logic [RATIO_W-1:0]  divCount_reg;
  logic [SETTLE_W-1:0] settle_reg;
  logic [SETTLE_W-1:0] settleTarget;
  conv_state_e         state_reg;
  conv_state_e         state_next;
  logic                frameSync;
  logic                modeChange;
  logic                syncRise;
  logic                periodEnd;

  assign pinsRaw = '{syncN: syncN, clockDividerSelect: clockDividerSelect,
                     mode: op_mode_e'(mode)};

  sync_two_stage #(
    .WIDTH     (4),
    .RESET_VAL (16'(CTRL_RESET))
  ) u_pinSync (
    .clock    (clock),
    .rst_b    (rst_b),
    .levelIn  (pinsRaw), // RULE_25
    .levelOut (pinsSync)
  );

  // protocol choice
  assign frameSync = (format >= FORMAT_FS_LO) && (format <= FORMAT_FS_HI); // RULE_23

  // ratio table
  always_comb begin
    unique case (pinsSync.mode) // RULE_02
      MODE_HIGH_SPEED: ratio_next = RATIO_256; // RULE_03
      MODE_HIGH_RES:   ratio_next = RATIO_512;
      MODE_LOW_POWER:  ratio_next = pinsSync.clockDividerSelect ? RATIO_512 : RATIO_256; // RULE_05
      MODE_LOW_SPEED:  ratio_next = pinsSync.clockDividerSelect ? RATIO_2560 : RATIO_512;
    endcase
  end

  assign settleTarget = frameSync ? SETTLE_FS : SETTLE_SPI; // RULE_08 RULE_09 RULE_22

  // previous pins for edge detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinsPrev_reg <= ctrl_pins_s'(CTRL_RESET[3:0]);
    end else begin
      pinsPrev_reg <= pinsSync;
    end
  end

  assign modeChange = (pinsSync.mode != pinsPrev_reg.mode) ||
                      (pinsSync.clockDividerSelect != pinsPrev_reg.clockDividerSelect); // RULE_07
  assign syncRise   = pinsSync.syncN && !pinsPrev_reg.syncN;

  // one shared period divider on the master clock
  assign periodEnd = (state_reg != ST_HALTED) &&
                     (divCount_reg == ratio_next - 12'h001); // RULE_01 RULE_06 RULE_13

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCount_reg <= '0;
    end else if (!pinsSync.syncN || modeChange || periodEnd) begin
      divCount_reg <= '0; // RULE_11 RULE_14
    end else if (state_reg != ST_HALTED) begin
      divCount_reg <= divCount_reg + 12'h001;
    end
  end

  // conversion state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HALTED:   if (pinsSync.syncN) state_next = ST_SETTLING; // RULE_12
      ST_SETTLING: if (periodEnd && settle_reg == settleTarget - 8'h01) state_next = ST_RUNNING;
      ST_RUNNING:  if (modeChange) state_next = ST_SETTLING;
      default:     state_next = ST_HALTED;
    endcase
    if (!pinsSync.syncN) begin
      state_next = ST_HALTED; // RULE_11
    end else if (modeChange) begin
      state_next = ST_SETTLING;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_HALTED;
    end else begin
      state_reg <= state_next;
    end
  end

  // settle counter in conversion periods
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= '0;
    end else if (!pinsSync.syncN || modeChange || syncRise) begin
      settle_reg <= '0; // RULE_26
    end else if (state_reg == ST_SETTLING && periodEnd) begin
      settle_reg <= settle_reg + 8'h01;
    end
  end

  // outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataValid <= 1'b0;
    end else begin
      dataValid <= (state_next == ST_RUNNING); // RULE_26
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sample_ready_n <= 1'b1;
    end else if (frameSync || state_next != ST_RUNNING) begin
      sample_ready_n <= 1'b1; // RULE_15 RULE_08 RULE_16
    end else if (periodEnd || state_reg != ST_RUNNING) begin
      sample_ready_n <= 1'b0; // RULE_24 RULE_16
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataOut <= '0;
    end else if (frameSync && state_next != ST_RUNNING) begin
      dataOut <= '0; // RULE_09 RULE_17
    end else begin
      dataOut <= rawData; // RULE_18
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      convStrobe  <= 1'b0;
      filterClear <= 1'b1;
      ratioOut    <= RATIO_256;
      modeOut     <= 2'h0;
    end else begin
      convStrobe  <= periodEnd; // RULE_13
      filterClear <= !pinsSync.syncN || modeChange; // RULE_11
      ratioOut    <= ratio_next;
      modeOut     <= pinsSync.mode;
    end
  end

endmodule

// ===== testbench/adc_ctrl_chk.sv
// Purpose: port assertions for mode, sync and settle control
// Assumes: one clock, async active-low reset
// Notes: bound to every control block instance
`timescale 1ns/1ns
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // pins and outputs
  input wire logic [1:0]  mode,
  input wire logic        syncN,
  input wire logic [2:0]  format,
  input wire logic        sample_ready_n,
  input wire logic [7:0]  dataOut,
  input wire logic        convStrobe,
  input wire logic        filterClear,
  input wire logic        dataValid,
  input wire logic [11:0] ratioOut,
  input wire logic [1:0]  modeOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_syncHeld; !syncN [*4]; endsequence
  sequence s_fsFormat; format >= FORMAT_FS_LO && format <= FORMAT_FS_HI; endsequence
  property p_syncClear; $fell(syncN) |-> ##3 (filterClear && !dataValid); endproperty
  a_syncClear: assert property (p_syncClear) else $error("no clear after sync fall");
  property p_spiReady; s_syncHeld ##0 (format < FORMAT_FS_LO) |-> sample_ready_n; endproperty
  a_spiReady: assert property (p_spiReady) else $error("ready low during sync");
  property p_fsLow; s_syncHeld ##0 s_fsFormat |-> dataOut == 8'h00; endproperty
  a_fsLow: assert property (p_fsLow) else $error("data not low during sync");
  property p_fsNoReady; s_fsFormat [*3] |-> sample_ready_n; endproperty
  a_fsNoReady: assert property (p_fsNoReady) else $error("ready low in frame-sync");
  property p_readyValid; $fell(sample_ready_n) |-> dataValid; endproperty
  a_readyValid: assert property (p_readyValid) else $error("ready before valid");
  property p_strobe; convStrobe |=> !convStrobe [*8]; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too frequent");
  property p_ratioFast;
    (!modeOut[1] && $stable(modeOut)) [*3] |-> ratioOut == (modeOut[0] ? RATIO_512 : RATIO_256);
  endproperty
  a_ratioFast: assert property (p_ratioFast) else $error("wrong ratio");
  property p_modeTrack; $stable(mode) [*6] |-> modeOut == mode; endproperty
  a_modeTrack: assert property (p_modeTrack) else $error("mode not tracked");
endmodule
bind adc_mode_clock_sync_control adc_ctrl_chk u_chk(.clock, .rst_b, .mode, .syncN, .format,
  .sample_ready_n, .dataOut, .convStrobe, .filterClear, .dataValid, .ratioOut, .modeOut);

// ===== testbench/host_ctrl_model.sv
// Purpose: host driving control pins and filter bits
// Assumes: pins change on the falling clock edge
// Notes: clock keeps running across sync release
`timescale 1ns/1ns
module host_ctrl_model
  import adc_ctrl_pkg::*;
(
  // master clock
  input wire logic   clock,
  // driven pins
  output ctrl_pins_s pins,
  output logic [2:0] format,
  output logic [7:0] rawData
);
  initial begin
    pins = '{1'b1, 1'b1, MODE_HIGH_SPEED};
    format = 3'h0;
    rawData = 8'hA5;
  end
  // caller holds sync low for several clocks
  task drive(input ctrl_pins_s p, input logic [2:0] f, input logic [7:0] d);
    @(negedge clock);
    pins = p;
    format = f;
    rawData = d;
  endtask
endmodule

// ===== testbench/adc_mode_clock_sync_control_tb.sv
// Purpose: self-checking bench for mode, sync and settle control
// Assumes: host model drives pins on the falling edge
// Notes: full settle counts run at 256 clocks a period
`timescale 1ns/1ns
module adc_mode_clock_sync_control_tb
  import adc_ctrl_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  ctrl_pins_s  pins;
  logic [2:0]  format;
  logic [7:0]  rawData;
  logic [7:0]  dataOut;
  logic        sample_ready_n;
  logic        filterClear;
  logic        dataValid;
  logic [11:0] ratioOut;
  logic [1:0]  modeOut;
  logic        convStrobe;
  int          errTotal = 0;
  int          nCompared = 0;
  logic [11:0] ratioTable [8] = '{RATIO_256, RATIO_256, RATIO_512, RATIO_512,
                                  RATIO_256, RATIO_512, RATIO_512, RATIO_2560};
  initial forever #10 clock = ~clock;
  host_ctrl_model u_host(.clock(clock), .pins(pins), .format(format), .rawData(rawData));
  adc_mode_clock_sync_control u_adc_mode_clock_sync_control(.clock(clock), .rst_b(rst_b),
    .mode(pins.mode), .clockDividerSelect(pins.clockDividerSelect), .syncN(pins.syncN),
    .format(format), .rawData(rawData), .sample_ready_n(sample_ready_n), .dataOut(dataOut),
    .convStrobe(convStrobe), .filterClear(filterClear), .dataValid(dataValid),
    .ratioOut(ratioOut), .modeOut(modeOut));
  task results;
    $display("compared %0d errors %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task pin(input logic s, d, input logic [1:0] m, input logic [2:0] f, input logic [7:0] r);
    u_host.drive('{s, d, op_mode_e'(m)}, f, r);
  endtask
  // host polls until data flagged valid, then checks the elapsed count
  task settle(input int lo, input int hi);
    int i;
    for (i = 0; i < 40000 && dataValid !== 1'b1; i++) step(1);
    if (i == 40000) begin
      errTotal++;
      results();
    end
    chk(12'(i > lo && i <= hi), 12'h001);
  endtask
  task t_reset;
    step(2);
    chk({9'h0, sample_ready_n, dataValid, filterClear}, 12'h005);
    chk(ratioOut, RATIO_256);
    rst_b = 1'b1;
  endtask
  task t_syncSpi;
    pin(0, 1, 0, 0, 8'hA5);
    step(4);
    chk({1'b0, sample_ready_n, dataValid, filterClear, dataOut}, 12'h5A5);
    pin(1, 1, 0, 0, 8'hA5);
    settle(128 * 256, 129 * 256 + 8);
    step(2);
    chk({3'h0, sample_ready_n, dataOut}, 12'h0A5);
  endtask
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      pin(1, i[0], i[2:1], 0, 8'hA5);
      step(6);
      chk(ratioOut, ratioTable[i]);
      chk({8'h0, modeOut, dataValid, sample_ready_n}, {8'h0, i[2:1], 2'b01});
    end
  endtask
  task t_syncFs;
    pin(0, 1, 0, 4, 8'hFF);
    step(4);
    chk({3'h0, sample_ready_n, dataOut}, 12'h100);
    pin(1, 1, 0, 4, 8'hFF);
    step(100);
    chk({3'h0, sample_ready_n, dataOut}, 12'h100);
    settle(127 * 256 - 100, 128 * 256 - 92);
    step(2);
    chk({3'h0, sample_ready_n, dataOut}, 12'h1FF);
  endtask
  task t_formats;
    for (int f = 0; f < 8; f++) begin
      pin(1, 1, 0, f[2:0], 8'hFF);
      step(300);
      chk({11'h0, sample_ready_n}, 12'(f >= 3 && f <= 5));
    end
  endtask
  // negedges until the strobe is seen, counted from one
  task waitStrobe(output int n);
    for (n = 1; n < 6000 && convStrobe !== 1'b1; n++) step(1);
    if (n == 6000) begin
      errTotal++;
      results();
    end
  endtask
  // clocks between two strobes after a mode change
  task period(input logic d, input logic [1:0] m, input logic [11:0] exp);
    int n;
    pin(1, d, m, 0, 8'hA5);
    step(4);
    waitStrobe(n);
    step(1);
    waitStrobe(n);
    chk(12'(n), exp);
  endtask
  task t_periods;
    period(1'b1, 2'h3, RATIO_2560);
    period(1'b0, 2'h2, RATIO_256);
    period(1'b1, 2'h1, RATIO_512);
  endtask
  initial begin
    t_reset;
    t_modes;
    t_syncSpi;
    t_syncFs;
    t_formats;
    t_periods;
    results;
  end
endmodule
